// file: verilog/cgo_pkg.sv
package cgo_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned NUM_REGS = 15;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned NUM_CH   = 3;
  localparam int unsigned DAC_W    = 10;
  localparam int unsigned LOW_W    = 2;

  // ----------------------------------------
  // Register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [3:0] IDX_GAIN_MODE    = 4'h0;
  localparam logic [3:0] IDX_RED_GAIN     = 4'h1;
  localparam logic [3:0] IDX_GREEN_GAIN   = 4'h2;
  localparam logic [3:0] IDX_BLUE_GAIN    = 4'h3;
  localparam logic [3:0] IDX_RED_EVEN_HI  = 4'h4;
  localparam logic [3:0] IDX_RED_EVEN_LO  = 4'h5;
  localparam logic [3:0] IDX_GRN_EVEN_HI  = 4'h6;
  localparam logic [3:0] IDX_GRN_EVEN_LO  = 4'h7;
  localparam logic [3:0] IDX_BLU_EVEN_HI  = 4'h8;
  localparam logic [3:0] IDX_BLU_EVEN_LO  = 4'h9;
  localparam logic [3:0] IDX_RED_ODD_HI   = 4'hA;
  localparam logic [3:0] IDX_RED_ODD_LO   = 4'hB;
  localparam logic [3:0] IDX_GRN_ODD_HI   = 4'hC;
  localparam logic [3:0] IDX_GRN_ODD_LO   = 4'hD;
  localparam logic [3:0] IDX_BLU_ODD_HI   = 4'hE;
  localparam int unsigned IDX_EVEN_BASE   = 4;
  localparam int unsigned IDX_ODD_BASE    = 10;

  // ----------------------------------------
  // Gain mode fields
  // ----------------------------------------
  localparam int unsigned GM_SEL_BIT   = 0;
  localparam int unsigned GM_DUAL_BIT  = 1;
  localparam int unsigned GM_INDIV_BIT = 2;
  localparam int unsigned GM_CH_LSB    = 5;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [7:0] GM_MASK   = 8'hE7;
  localparam logic [7:0] LOW_MASK  = 8'h03;
  localparam logic [7:0] FULL_MASK = 8'hFF;

  localparam logic [7:0] RST_GAIN_MODE = 8'h00;
  localparam logic [7:0] RST_PGA       = 8'h61;
  localparam logic [7:0] RST_DAC_HI    = 8'h80;
  localparam logic [7:0] RST_DAC_LO    = 8'h00;
  localparam logic [1:0] BLUE_ODD_LOW  = 2'h0;
  localparam logic [9:0] DAC_RST_CODE  = {RST_DAC_HI, 2'h0};
  localparam logic [23:0] RD_PAD       = 24'h000000;

  localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_MASKS = {
    FULL_MASK, LOW_MASK, FULL_MASK, LOW_MASK, FULL_MASK,
    LOW_MASK, FULL_MASK, LOW_MASK, FULL_MASK, LOW_MASK,
    FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, GM_MASK};

  localparam logic [NUM_REGS-1:0][REG_W-1:0] RST_VALS = {
    RST_DAC_HI, RST_DAC_LO, RST_DAC_HI, RST_DAC_LO, RST_DAC_HI,
    RST_DAC_LO, RST_DAC_HI, RST_DAC_LO, RST_DAC_HI, RST_DAC_LO,
    RST_DAC_HI, RST_PGA, RST_PGA, RST_PGA, RST_GAIN_MODE};

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} cgo_apb_st_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } cgo_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } cgo_apb_rsp_t;

  typedef struct packed {
    logic [NUM_CH-1:0]            cds_2x;
    logic                         dual_en;
    logic [NUM_CH-1:0][REG_W-1:0] pga;
  } cgo_gain_t;

  typedef struct packed {
    logic [NUM_CH-1:0][DAC_W-1:0] even;
    logic [NUM_CH-1:0][DAC_W-1:0] odd;
  } cgo_dac_t;

  typedef struct packed {
    cgo_apb_st_t                    st;
    logic [NUM_REGS-1:0][REG_W-1:0] regs;
    logic [IDX_W-1:0]               idx;
    logic                           hit;
    cgo_apb_rsp_t                   rsp;
    cgo_gain_t                      gain;
    cgo_dac_t                       dac;
  } cgo_state_t;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[7:2] < 6'(NUM_REGS));
  endfunction

  function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] a);
    return a[5:2];
  endfunction

endpackage

// file: verilog/cgo_gain_sel.sv
`timescale 1ns/1ps

module cgo_gain_sel
  import cgo_pkg::*;
(
  input  wire logic [REG_W-1:0]  i_mode,
  output wire logic [NUM_CH-1:0] o_eff_2x
);

  // ----------------------------------------
  // Per-channel sampling_stage gain source
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign o_eff_2x[ch] = i_mode[GM_INDIV_BIT] ? i_mode[GM_CH_LSB + ch]
                                                 : i_mode[GM_SEL_BIT];
    end
  endgenerate

endmodule

// file: verilog/cgo_dac_join.sv
`timescale 1ns/1ps

module cgo_dac_join
  import cgo_pkg::*;
(
  input  wire logic [NUM_REGS-1:0][REG_W-1:0] i_regs,
  output cgo_dac_t                            o_dac
);

  wire logic [NUM_CH-1:0][DAC_W-1:0] even_w;
  wire logic [NUM_CH-1:0][DAC_W-1:0] odd_w;

  // ----------------------------------------
  // High byte is code 9:2, low byte holds 1:0
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam int unsigned EH = IDX_EVEN_BASE + 2 * ch;
      localparam int unsigned OH = IDX_ODD_BASE + 2 * ch;
      assign even_w[ch] = {i_regs[EH], i_regs[EH + 1][LOW_W-1:0]};
      if (OH + 1 < NUM_REGS) begin : g_low
        assign odd_w[ch] = {i_regs[OH], i_regs[OH + 1][LOW_W-1:0]};
      end else begin : g_nolow
        // Blue odd low bits are not held here
        assign odd_w[ch] = {i_regs[OH], BLUE_ODD_LOW};
      end
    end
  endgenerate

  assign o_dac = '{even: even_w, odd: odd_w};

endmodule

// file: verilog/cgo_regs.sv
`timescale 1ns/1ps

module cgo_regs
  import cgo_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire cgo_apb_req_t i_apb,
  output cgo_apb_rsp_t      o_apb,
  output cgo_gain_t         o_gain,
  output cgo_dac_t          o_dac
);

  // ----------------------------------------
  // Reset image
  // ----------------------------------------
  localparam cgo_gain_t GAIN_RST = '{
    cds_2x:  3'h0,
    dual_en: 1'b0,
    pga:     {NUM_CH{RST_PGA}}
  };

  localparam cgo_dac_t DAC_RST = '{
    even: {NUM_CH{DAC_RST_CODE}},
    odd:  {NUM_CH{DAC_RST_CODE}}
  };

  localparam cgo_state_t ST_RST_VAL = '{
    st:   ST_IDLE,
    regs: RST_VALS,
    idx:  4'h0,
    hit:  1'b0,
    rsp:  '0,
    gain: GAIN_RST,
    dac:  DAC_RST
  };

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  cgo_state_t        st_r;
  cgo_state_t        st_nxt;
  logic              setup_req;
  logic              acc_req;
  logic              wr_fire;
  logic              req_hit;
  logic [IDX_W-1:0]  req_idx;
  logic [REG_W-1:0]  mode;
  logic [NUM_CH-1:0] eff_2x;
  cgo_dac_t          dac_code;

  // ----------------------------------------
  // Bus phase decode
  // ----------------------------------------
  assign setup_req = i_apb.psel && !i_apb.penable;
  assign acc_req   = i_apb.psel && i_apb.penable && (st_r.st == ST_ACCESS);
  assign wr_fire   = acc_req && i_apb.pwrite && st_r.hit;
  assign req_hit   = addr_hit(i_apb.paddr);
  assign req_idx   = reg_idx(i_apb.paddr);
  assign mode      = st_r.regs[IDX_GAIN_MODE];

  // ----------------------------------------
  // Derived settings
  // ----------------------------------------
  cgo_gain_sel u_gain_sel (
    .i_mode   (mode),
    .o_eff_2x (eff_2x)
  );

  cgo_dac_join u_dac_join (
    .i_regs (st_r.regs),
    .o_dac  (dac_code)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;

    st_nxt.gain.cds_2x  = eff_2x;
    st_nxt.gain.dual_en = mode[GM_DUAL_BIT];
    for (int ch = 0; ch < NUM_CH; ch++) begin
      st_nxt.gain.pga[ch] = st_r.regs[int'(IDX_RED_GAIN) + ch];
    end
    st_nxt.dac = dac_code;

    case (st_r.st)
      ST_IDLE: begin
        st_nxt.rsp = '0;
        if (setup_req) begin
          st_nxt.st          = ST_ACCESS;
          st_nxt.hit         = req_hit;
          st_nxt.idx         = req_idx;
          st_nxt.rsp.pready  = 1'b1;
          st_nxt.rsp.pslverr = !req_hit;
          if (req_hit && !i_apb.pwrite) begin
            // Reserved bits are stored as zero, so read back as zero
            st_nxt.rsp.prdata = {RD_PAD, st_r.regs[req_idx]};
          end
        end
      end
      ST_ACCESS: begin
        // Single access cycle: pready is already high here
        st_nxt.st  = ST_IDLE;
        st_nxt.rsp = '0;
        if (wr_fire) begin
          st_nxt.regs[st_r.idx] = i_apb.pwdata[REG_W-1:0]
                                  & REG_MASKS[st_r.idx];
        end
      end
      default: begin
        st_nxt = ST_RST_VAL;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_apb  = st_r.rsp;
  assign o_gain = st_r.gain;
  assign o_dac  = st_r.dac;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic fresh_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  gain_global_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !mode[GM_INDIV_BIT] |=>
      o_gain.cds_2x == {NUM_CH{$past(mode[GM_SEL_BIT])}}
  ) else $error("global gain select not applied to all channels");

  gain_indiv_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    mode[GM_INDIV_BIT] |=>
      o_gain.cds_2x == $past(mode[7:5])
  ) else $error("per-channel gain bits not applied");

  chan_order_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (mode[GM_INDIV_BIT] && (mode[7] != mode[5])) |=>
      (o_gain.cds_2x[2] == $past(mode[7])) &&
      (o_gain.cds_2x[1] == $past(mode[6])) &&
      (o_gain.cds_2x[0] == $past(mode[5]))
  ) else $error("per-channel gain bit order wrong");

  dual_mode_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_GAIN_MODE)) |=> ##1
      o_gain.dual_en == $past(i_apb.pwdata[GM_DUAL_BIT], 2)
  ) else $error("dual gain enable does not follow write");

  pga_reset_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    fresh_r |->
      (o_gain.pga == {NUM_CH{RST_PGA}}) &&
      (st_r.regs[IDX_BLUE_GAIN] == RST_PGA)
  ) else $error("channel gain reset value wrong");

  pga_write_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_GREEN_GAIN)) |=> ##1
      o_gain.pga[1] == $past(i_apb.pwdata[REG_W-1:0], 2)
  ) else $error("green gain does not follow write");

  dac_reset_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    fresh_r |->
      (o_dac.even == {NUM_CH{DAC_RST_CODE}}) &&
      (o_dac.odd == {NUM_CH{DAC_RST_CODE}})
  ) else $error("offset code reset value wrong");

  dac_low_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_RED_EVEN_LO)) |=> ##1
      o_dac.even[0][LOW_W-1:0] == $past(i_apb.pwdata[LOW_W-1:0], 2)
  ) else $error("red even offset low bits not joined");

  dac_high_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_GRN_ODD_HI)) |=> ##1
      o_dac.odd[1][DAC_W-1:LOW_W] == $past(i_apb.pwdata[REG_W-1:0], 2)
  ) else $error("green odd offset high byte not joined");

  rsvd_read_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (o_apb.pready && !o_apb.pslverr) |->
      (o_apb.prdata[REG_W-1:0] & ~REG_MASKS[st_r.idx]) == 8'h00
  ) else $error("unused bits read back nonzero");

  ready_pulse_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_apb.pready |=> !o_apb.pready
  ) else $error("pready held longer than one cycle");

  ready_setup_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (setup_req && (st_r.st == ST_IDLE)) |=> o_apb.pready
  ) else $error("no answer in the cycle after setup");

  miss_err_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (setup_req && (st_r.st == ST_IDLE) && !req_hit) |=>
      (o_apb.pslverr && (o_apb.prdata == 32'h00000000))
  ) else $error("unmapped access not flagged");

  // ----------------------------------------
  // Storage, readback, derived-output and bus checks
  // ----------------------------------------
  regs_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !wr_fire |=> st_r.regs == $past(st_r.regs)
  ) else $error("register changed without an accepted write");

  low_rsvd_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.regs[IDX_RED_EVEN_LO][7:2] | st_r.regs[IDX_GRN_EVEN_LO][7:2] |
     st_r.regs[IDX_BLU_EVEN_LO][7:2] | st_r.regs[IDX_RED_ODD_LO][7:2] |
     st_r.regs[IDX_GRN_ODD_LO][7:2]) == 6'h00
  ) else $error("unused offset low bits stored");

  gm_rsvd_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    mode[4:3] == 2'h0
  ) else $error("unused gain mode bits stored");

  blue_odd_low_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_dac.odd[2][LOW_W-1:0] == BLUE_ODD_LOW
  ) else $error("blue odd offset low bits not fixed");

  dual_follow_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    1'b1 |=> o_gain.dual_en == $past(mode[GM_DUAL_BIT])
  ) else $error("dual gain enable does not follow mode");

  pga_red_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_RED_GAIN)) |=> ##1
      o_gain.pga[0] == $past(i_apb.pwdata[REG_W-1:0], 2)
  ) else $error("red gain does not follow write");

  pga_blue_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_BLUE_GAIN)) |=> ##1
      o_gain.pga[2] == $past(i_apb.pwdata[REG_W-1:0], 2)
  ) else $error("blue gain does not follow write");

  dac_blue_even_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_BLU_EVEN_HI)) |=> ##1
      o_dac.even[2][DAC_W-1:LOW_W] == $past(i_apb.pwdata[REG_W-1:0], 2)
  ) else $error("blue even offset high byte not joined");

  dac_odd_low_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_fire && (st_r.idx == IDX_RED_ODD_LO)) |=> ##1
      o_dac.odd[0][LOW_W-1:0] == $past(i_apb.pwdata[LOW_W-1:0], 2)
  ) else $error("red odd offset low bits not joined");

  mode_reset_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    fresh_r |->
      (o_gain.cds_2x == 3'h0) && !o_gain.dual_en &&
      (mode == RST_GAIN_MODE)
  ) else $error("gain mode reset value wrong");

  err_with_ready_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_apb.pslverr |-> o_apb.pready
  ) else $error("error flag without pready");

  idle_quiet_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.st == ST_IDLE) |-> !o_apb.pready
  ) else $error("pready high while idle");

  read_back_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (setup_req && (st_r.st == ST_IDLE) && req_hit && !i_apb.pwrite) |=>
      (o_apb.prdata == {RD_PAD, $past(st_r.regs[req_idx])})
  ) else $error("read data does not match register");

endmodule

// file: testbench/test_cgo_regs.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module test_cgo_regs
  import cgo_pkg::*;
();
  logic         i_core_clk;
  logic         i_rst_n;
  cgo_apb_req_t i_apb;
  cgo_apb_rsp_t o_apb;
  cgo_gain_t    o_gain;
  cgo_dac_t     o_dac;
  int           err_total;
  int           checks_done;
  logic [31:0]  rd_data;
  logic         rd_err;
  logic         chain;
  logic         held;

  localparam logic [7:0] MODES [10] = '{8'h00, 8'h01, 8'h02, 8'hE1, 8'hE4,
                                        8'h24, 8'h44, 8'h84, 8'h85, 8'hFF};
  localparam logic [7:0] PGA_V [3]  = '{8'h00, 8'hFF, 8'h7E};

  cgo_regs dut (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_apb      (i_apb),
    .o_apb      (o_apb),
    .o_gain     (o_gain),
    .o_dac      (o_dac)
  );

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic xfer(input logic is_wr, input int idx, input logic [1:0] lsb,
                      input logic [31:0] wd);
    int n;
    n = 0;
    // A chained call starts its setup on the previous access edge
    if (!held) begin
      @(posedge i_core_clk);
    end
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: is_wr,
               paddr: 8'(idx * 4) | 8'(lsb), pwdata: wd};
    @(posedge i_core_clk);
    i_apb.penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_apb.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("ERROR pready exp 1 got 0");
    end
    rd_data = o_apb.prdata;
    rd_err  = o_apb.pslverr;
    held    = chain;
    if (!chain) begin
      i_apb <= '0;
    end
  endtask

  task automatic wr(input int idx, input logic [7:0] v);
    xfer(1'b1, idx, 2'b00, {24'h5A5A5A, v});
  endtask

  task automatic rdchk(input int idx, input logic [7:0] e);
    xfer(1'b0, idx, 2'b00, 32'h0);
    `CHK("prdata", {24'h0, e}, rd_data)
    `CHK("pslverr", 1'b0, rd_err)
  endtask

  // Derived outputs follow one edge after the register write
  task automatic settle();
    repeat (2) @(negedge i_core_clk);
  endtask

  function automatic logic [7:0] rst_exp(input int i);
    if (i == 0) return 8'h00;
    if (i < 4) return 8'h61;
    return (i % 2 == 0) ? 8'h80 : 8'h00;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 15; i++) rdchk(i, rst_exp(i));
    `CHK("cds_2x", 3'h0, o_gain.cds_2x)
    `CHK("dual_en", 1'b0, o_gain.dual_en)
    for (int c = 0; c < 3; c++) begin
      `CHK("pga", 8'h61, o_gain.pga[c])
      `CHK("even", 10'h200, o_dac.even[c])
      `CHK("odd", 10'h200, o_dac.odd[c])
    end
  endtask

  task automatic t_gain_mode();
    logic [7:0] v;
    logic [2:0] e;
    for (int k = 0; k < 10; k++) begin
      v = MODES[k];
      e = v[2] ? v[7:5] : {3{v[0]}};
      wr(0, v);
      settle();
      `CHK("cds_2x", e, o_gain.cds_2x)
      `CHK("dual_en", v[1], o_gain.dual_en)
      rdchk(0, v & 8'hE7);
    end
  endtask

  task automatic t_pga();
    for (int c = 0; c < 3; c++) wr(c + 1, PGA_V[c]);
    settle();
    for (int c = 0; c < 3; c++) begin
      `CHK("pga", PGA_V[c], o_gain.pga[c])
      rdchk(c + 1, PGA_V[c]);
    end
  endtask

  task automatic t_dac();
    logic [7:0] hi;
    logic [7:0] lo;
    logic [9:0] e;
    int         b;
    for (int k = 0; k < 6; k++) begin
      b  = (k % 2 ? 10 : 4) + 2 * (k / 2);
      hi = 8'h5A ^ 8'(k * 19);
      lo = 8'hFC | 8'(k);
      e  = {hi, (k == 5) ? 2'b00 : lo[1:0]};
      wr(b, hi);
      if (k != 5) wr(b + 1, lo);
      settle();
      if (k % 2) `CHK("odd", e, o_dac.odd[k / 2])
      else `CHK("even", e, o_dac.even[k / 2])
      rdchk(b, hi);
      if (k != 5) rdchk(b + 1, lo & 8'h03);
    end
  endtask

  task automatic t_refuse();
    xfer(1'b1, 15, 2'b00, 32'hFF);
    `CHK("pslverr", 1'b1, rd_err)
    xfer(1'b0, 15, 2'b00, 32'h0);
    `CHK("pslverr", 1'b1, rd_err)
    `CHK("prdata", 32'h0, rd_data)
    xfer(1'b1, 1, 2'b01, 32'h33);
    `CHK("pslverr", 1'b1, rd_err)
    rdchk(1, PGA_V[0]);
  endtask

  task automatic t_b2b();
    chain = 1'b1;
    wr(3, 8'hA5);
    wr(2, 8'h3C);
    xfer(1'b0, 3, 2'b00, 32'h0);
    `CHK("prdata", 32'h000000A5, rd_data)
    chain = 1'b0;
    xfer(1'b0, 2, 2'b00, 32'h0);
    `CHK("prdata", 32'h0000003C, rd_data)
    `CHK("pslverr", 1'b0, rd_err)
    settle();
    `CHK("pga", 8'hA5, o_gain.pga[2])
    `CHK("pga", 8'h3C, o_gain.pga[1])
  endtask

  task automatic t_midrst();
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rdchk(0, 8'h00);
    rdchk(1, 8'h61);
    `CHK("odd", 10'h200, o_dac.odd[2])
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  initial begin
    i_rst_n     = 1'b0;
    i_apb       = '0;
    err_total   = 0;
    checks_done = 0;
    chain       = 1'b0;
    held        = 1'b0;
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_gain_mode();
    t_pga();
    t_dac();
    t_refuse();
    t_b2b();
    t_midrst();
    end_sim();
  end
endmodule
